/* include/field_dec_pkg.sv */
/*
 * Constants for the control-structure field encoding decoder: encoding
 * bit positions, width and type codes, field identity bases, capability
 * masks and register offsets, including the status register offset.
 * Assumes one synchronous clock domain and a plain register port.
 */
// Notes on behaviour
// - Width code 0 means a 16-bit field
// - 16-bit encodings with bit 0 set invalid
// - Type code 0 means a control field
// - Index bits 9:1 tell fields apart
// - Type code 2 means guest-state area
// - Type code 3 means host-state area
// - Width code 1 means a 64-bit field
// - 64-bit field: even full, odd high half
// - Map 16-bit control encodings to fields
// - Map 16-bit guest-state encodings to fields
// - Map 16-bit host selector encodings in order
// - Map 64-bit control pairs 2000H through 2029H
// - Optional field present only with control support
// - User vector present if either control supported
// - Nonzero bits 31:15 or 12 are invalid
package field_dec_pkg;

	// ************************************************************
	// Encoding layout
	// ************************************************************
	localparam int RSVD_HI    = 31;
	localparam int RSVD_LO    = 15;
	localparam int WIDTH_HI   = 14;
	localparam int WIDTH_LO   = 13;
	localparam int RSVD_BIT   = 12;
	localparam int TYPE_HI    = 11;
	localparam int TYPE_LO    = 10;
	localparam int IDX_HI     = 9;
	localparam int IDX_LO     = 1;
	localparam int ACCESS_BIT = 0;

	localparam logic [1:0] W16     = 2'h0;
	localparam logic [1:0] W64     = 2'h1;
	localparam logic [1:0] T_CTRL  = 2'h0;
	localparam logic [1:0] T_GUEST = 2'h2;
	localparam logic [1:0] T_HOST  = 2'h3;

	// ************************************************************
	// Table groups, last index and identity base of each
	// ************************************************************
	localparam logic [1:0] G_C16 = 2'h0;
	localparam logic [1:0] G_G16 = 2'h1;
	localparam logic [1:0] G_H16 = 2'h2;
	localparam logic [1:0] G_C64 = 2'h3;

	localparam logic [8:0] C16_LAST = 9'h004;
	localparam logic [8:0] G16_LAST = 9'h00A;
	localparam logic [8:0] H16_LAST = 9'h006;
	localparam logic [8:0] C64_LAST = 9'h014;

	localparam logic [5:0] ID_NONE = 6'h00;
	localparam logic [5:0] ID_C16  = 6'h01;
	localparam logic [5:0] ID_G16  = 6'h06;
	localparam logic [5:0] ID_H16  = 6'h11;
	localparam logic [5:0] ID_C64  = 6'h18;

	// ************************************************************
	// Supported execution controls, one bit each, two bits for the user vector
	// ************************************************************
	localparam int CAP_W = 16;
	localparam logic [15:0] M_NONE       = 16'h0000;
	localparam logic [15:0] M_VPROC_ID   = 16'h0001;
	localparam logic [15:0] M_POSTED     = 16'h0002;
	localparam logic [15:0] M_VE         = 16'h0004;
	localparam logic [15:0] M_LIN_XLAT   = 16'h0008;
	localparam logic [15:0] M_IPI        = 16'h0010;
	localparam logic [15:0] M_VINTR      = 16'h0020;
	localparam logic [15:0] M_PAGE_LOG   = 16'h0040;
	localparam logic [15:0] M_USER_VEC   = 16'h0180;
	localparam logic [15:0] M_MSRBMP     = 16'h0200;
	localparam logic [15:0] M_TPR        = 16'h0400;
	localparam logic [15:0] M_APICACC    = 16'h0800;
	localparam logic [15:0] M_VMFUNC     = 16'h1000;
	localparam logic [15:0] M_EPT        = 16'h2000;
	localparam logic [15:0] M_EPTPSW     = 16'h4000;
	localparam logic [15:0] M_SHADOW     = 16'h8000;
	localparam logic [15:0] CAP_RESET    = 16'h0000;

	// ************************************************************
	// Register map, one offset per register
	// ************************************************************
	localparam logic [7:0] CAP_ADDR   = 8'h00;
	localparam logic [7:0] STAT_ADDR  = 8'h04;
	localparam logic [7:0] COUNT_ADDR = 8'h08;

endpackage

/* hw/field_presence.sv */
/*
 * Table lookup: given a table group and an index, tells whether the
 * field is tabulated and whether it exists on this configuration.
 * Assumes the capability vector is stable for the decode cycle.
 */
`timescale 1ns/1ns
module field_presence
	import field_dec_pkg::*;
(
	// Lookup key
	input  logic [1:0]       grp_i,
	input  logic [8:0]       idx_i,
	// Supported controls
	input  logic [CAP_W-1:0] cap_i,
	// Result
	output logic             known_o,
	output logic             present_o
);

	// ************************************************************
	// Needed controls per field, any one suffices
	// ************************************************************
	function automatic logic [CAP_W-1:0] need_mask(input logic [1:0] g,
		input logic [8:0] i);
		logic [CAP_W-1:0] m;
		m = M_NONE;
		case (g)
			G_C16: begin
				case (i)
					9'h000: m = M_VPROC_ID;
					9'h001: m = M_POSTED;
					9'h002: m = M_VE;
					9'h003: m = M_LIN_XLAT;
					9'h004: m = M_IPI;
					default: m = M_NONE;
				endcase
			end
			G_G16: begin
				case (i)
					9'h008: m = M_VINTR;
					9'h009: m = M_PAGE_LOG;
					9'h00A: m = M_USER_VEC;
					default: m = M_NONE;
				endcase
			end
			G_C64: begin
				case (i)
					9'h002: m = M_MSRBMP;
					9'h007: m = M_PAGE_LOG;
					9'h009: m = M_TPR;
					9'h00A: m = M_APICACC;
					9'h00B: m = M_POSTED;
					9'h00C: m = M_VMFUNC;
					9'h00D: m = M_EPT;
					9'h00E, 9'h00F, 9'h010, 9'h011: m = M_VINTR;
					9'h012: m = M_EPTPSW;
					9'h013, 9'h014: m = M_SHADOW;
					default: m = M_NONE;
				endcase
			end
			default: m = M_NONE;
		endcase
		return m;
	endfunction

	// ************************************************************
	// Last tabulated index per group
	// ************************************************************
	wire logic [8:0]       last_idx;
	wire logic [CAP_W-1:0] need;

	assign last_idx  = (grp_i == G_C16) ? C16_LAST :
	                   (grp_i == G_G16) ? G16_LAST :
	                   (grp_i == G_H16) ? H16_LAST : C64_LAST;
	assign known_o   = (idx_i <= last_idx);
	assign need      = need_mask(grp_i, idx_i);
	assign present_o = known_o && ((need == M_NONE) || (|(need & cap_i)));

endmodule // field_presence

/* hw/vm_field_encoding_decoder.sv */
/*
 * Decoder for field encodings of the vm_control_structure, as used by
 * field_read_instr and field_write_instr. Splits an encoding into
 * width, type, index and access parts, checks it, maps it to a field
 * identity and reports presence against the supported controls.
 * Assumes requests synchronous to clock_i; results one cycle later.
 */
`timescale 1ns/1ns
module vm_field_encoding_decoder
	import field_dec_pkg::*;
(
	// Clock, reset, enable
	input  logic        clock_i,
	input  logic        rst_i,
	input  logic        ce_i,
	// Decode request
	input  logic        req_i,
	input  logic [31:0] enc_i,
	// Decode result
	output logic        done_o,
	output logic [5:0]  field_id_o,
	output logic [1:0]  width_o,
	output logic [1:0]  type_o,
	output logic [8:0]  index_o,
	output logic        high_o,
	output logic        present_o,
	output logic        invalid_o,
	// Register port
	input  logic [7:0]  addr_i,
	input  logic [31:0] wdata_i,
	input  logic        wr_i,
	input  logic        rd_i,
	output logic [31:0] rdata_o
);

	// ************************************************************
	// Encoding split
	// ************************************************************
	wire logic [1:0] enc_width;
	wire logic [1:0] enc_type;
	wire logic [8:0] enc_idx;
	wire logic       enc_acc;
	wire logic       rsvd_bad;
	wire logic       is16;
	wire logic       is64;
	wire logic       odd16_bad;

	assign enc_width = enc_i[WIDTH_HI:WIDTH_LO];
	assign enc_type  = enc_i[TYPE_HI:TYPE_LO];
	assign enc_idx   = enc_i[IDX_HI:IDX_LO];
	assign enc_acc   = enc_i[ACCESS_BIT];
	assign rsvd_bad  = (|enc_i[RSVD_HI:RSVD_LO]) || enc_i[RSVD_BIT];
	assign is16      = (enc_width == W16);
	assign is64      = (enc_width == W64);
	assign odd16_bad = is16 && enc_acc;

	// ************************************************************
	// Table group selection
	// ************************************************************
	wire logic       hit_c16;
	wire logic       hit_g16;
	wire logic       hit_h16;
	wire logic       hit_c64;
	wire logic       grp_hit;
	wire logic [1:0] grp;

	assign hit_c16 = is16 && (enc_type == T_CTRL);
	assign hit_g16 = is16 && (enc_type == T_GUEST);
	assign hit_h16 = is16 && (enc_type == T_HOST);
	assign hit_c64 = is64 && (enc_type == T_CTRL);
	assign grp_hit = hit_c16 || hit_g16 || hit_h16 || hit_c64;
	assign grp     = hit_g16 ? G_G16 :
	                 hit_h16 ? G_H16 :
	                 hit_c64 ? G_C64 : G_C16;

	// ************************************************************
	// Identity and presence
	// ************************************************************
	function automatic logic [5:0] id_base(input logic [1:0] g);
		logic [5:0] b;
		b = ID_C16;
		case (g)
			G_C16:   b = ID_C16;
			G_G16:   b = ID_G16;
			G_H16:   b = ID_H16;
			G_C64:   b = ID_C64;
			default: b = ID_NONE;
		endcase
		return b;
	endfunction

	logic [CAP_W-1:0] cap_reg;
	wire logic        known;
	wire logic        present;
	wire logic        bad;
	wire logic [5:0]  id_next;
	wire logic        high_next;

	field_presence u_presence (
		.grp_i     (grp),
		.idx_i     (enc_idx),
		.cap_i     (cap_reg),
		.known_o   (known),
		.present_o (present)
	);

	assign bad       = rsvd_bad || odd16_bad || !grp_hit || !known || !present;
	assign id_next   = (rsvd_bad || !grp_hit || !known) ? ID_NONE :
	                   6'(id_base(grp) + enc_idx[5:0]);
	assign high_next = is64 && enc_acc;

	// ************************************************************
	// Result registers
	// ************************************************************
	wire logic req_take;
	assign req_take = ce_i && req_i;

	logic       done_reg;
	logic [5:0] id_reg;
	logic [1:0] width_reg;
	logic [1:0] type_reg;
	logic [8:0] index_reg;
	logic       high_reg;
	logic       present_reg;
	logic       invalid_reg;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			done_reg <= 1'b0;
		end else if (ce_i) begin
			done_reg <= req_i;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			id_reg      <= ID_NONE;
			width_reg   <= 2'h0;
			type_reg    <= 2'h0;
			index_reg   <= 9'h000;
			high_reg    <= 1'b0;
			present_reg <= 1'b0;
			invalid_reg <= 1'b0;
		end else if (req_take) begin
			id_reg      <= id_next;
			width_reg   <= enc_width;
			type_reg    <= enc_type;
			index_reg   <= enc_idx;
			high_reg    <= high_next;
			present_reg <= present && !rsvd_bad && !odd16_bad && grp_hit;
			invalid_reg <= bad;
		end
	end

	assign done_o     = done_reg;
	assign field_id_o = id_reg;
	assign width_o    = width_reg;
	assign type_o     = type_reg;
	assign index_o    = index_reg;
	assign high_o     = high_reg;
	assign present_o  = present_reg;
	assign invalid_o  = invalid_reg;

	// ************************************************************
	// Register port
	// ************************************************************
	wire logic        wr_cap;
	wire logic        wr_count;
	wire logic [31:0] stat_word;
	wire logic [31:0] rd_mux;
	logic [15:0]      count_reg;
	logic [15:0]      count_next;
	logic [31:0]      rdata_reg;

	assign wr_cap    = ce_i && wr_i && (addr_i == CAP_ADDR);
	assign wr_count  = ce_i && wr_i && (addr_i == COUNT_ADDR);
	assign stat_word = {10'h000, type_reg, width_reg, index_reg, present_reg,
	                    invalid_reg, high_reg, id_reg};
	assign rd_mux    = (addr_i == CAP_ADDR)   ? {16'h0000, cap_reg} :
	                   (addr_i == STAT_ADDR)  ? stat_word :
	                   (addr_i == COUNT_ADDR) ? {16'h0000, count_reg} : 32'h00000000;

	always_comb begin
		count_next = count_reg;
		if (wr_count) begin
			count_next = 16'h0000;
		end
		if (req_take && bad) begin
			count_next = wr_count ? 16'h0001 : 16'(count_reg + 16'h0001);
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cap_reg <= CAP_RESET;
		end else if (wr_cap) begin
			cap_reg <= wdata_i[CAP_W-1:0];
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			count_reg <= 16'h0000;
		end else if (ce_i) begin
			count_reg <= count_next;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= 32'h00000000;
		end else if (ce_i) begin
			rdata_reg <= rd_i ? rd_mux : 32'h00000000;
		end
	end

	assign rdata_o = rdata_reg;

	// ************************************************************
	// Checks
	// ************************************************************
	sequence s_take;
		ce_i && req_i;
	endsequence

	sequence s_answer;
		done_o;
	endsequence

	sequence s_take_enc(logic [31:0] e);
		ce_i && req_i && (enc_i == e);
	endsequence

	property p_answer;
		@(posedge clock_i) disable iff (rst_i)
		s_take |=> s_answer;
	endproperty
	a_answer: assert property (p_answer)
		else $error("no answer one cycle after a request");

	property p_rsvd;
		@(posedge clock_i) disable iff (rst_i)
		(s_take and (rsvd_bad == 1'b1)) |=> (invalid_o && !present_o && field_id_o == ID_NONE);
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved bits set but encoding accepted");

	property p_odd16;
		@(posedge clock_i) disable iff (rst_i)
		(s_take and (enc_i[WIDTH_HI:WIDTH_LO] == 2'h0) and enc_i[ACCESS_BIT])
		|=> invalid_o;
	endproperty
	a_odd16: assert property (p_odd16)
		else $error("odd 16-bit encoding accepted");

	property p_width16;
		@(posedge clock_i) disable iff (rst_i)
		(s_take and (enc_i[WIDTH_HI:WIDTH_LO] == 2'h0)) |=> (width_o == W16);
	endproperty
	a_width16: assert property (p_width16)
		else $error("16-bit width not reported");

	property p_index;
		@(posedge clock_i) disable iff (rst_i)
		s_take |=> (index_o == $past(enc_i[IDX_HI:IDX_LO]));
	endproperty
	a_index: assert property (p_index)
		else $error("index field not carried to output");

	property p_high64;
		@(posedge clock_i) disable iff (rst_i)
		(s_take and (enc_i[WIDTH_HI:WIDTH_LO] == 2'h1)) |=> (high_o == $past(enc_i[ACCESS_BIT]));
	endproperty
	a_high64: assert property (p_high64)
		else $error("64-bit access type wrong");

	property p_vproc_id;
		@(posedge clock_i) disable iff (rst_i)
		s_take_enc(32'h00000000) |=>
		(field_id_o == ID_C16 && present_o == $past(cap_reg[0]) && invalid_o == !present_o);
	endproperty
	a_vproc_id: assert property (p_vproc_id)
		else $error("processor identifier encoding misdecoded");

	property p_guest_intr;
		@(posedge clock_i) disable iff (rst_i)
		s_take_enc(32'h00000810) |=>
		(field_id_o == 6'h0E && present_o == $past(cap_reg[5]));
	endproperty
	a_guest_intr: assert property (p_guest_intr)
		else $error("guest interrupt status misdecoded");

	property p_host_task;
		@(posedge clock_i) disable iff (rst_i)
		s_take_enc(32'h00000C0C) |=> (field_id_o == 6'h17 && present_o && !invalid_o);
	endproperty
	a_host_task: assert property (p_host_task)
		else $error("host task selector misdecoded");

	property p_user_vec;
		@(posedge clock_i) disable iff (rst_i)
		s_take_enc(32'h00000814) |=>
		(present_o == ($past(cap_reg[7]) || $past(cap_reg[8])));
	endproperty
	a_user_vec: assert property (p_user_vec)
		else $error("user vector presence wrong");

	property p_last64;
		@(posedge clock_i) disable iff (rst_i)
		s_take_enc(32'h00002029) |=>
		(field_id_o == 6'h2C && high_o && present_o == $past(cap_reg[15]));
	endproperty
	a_last64: assert property (p_last64)
		else $error("last 64-bit control pair misdecoded");

	property p_beyond64;
		@(posedge clock_i) disable iff (rst_i)
		s_take_enc(32'h0000202A) |=> (invalid_o && field_id_o == ID_NONE);
	endproperty
	a_beyond64: assert property (p_beyond64)
		else $error("untabulated 64-bit encoding accepted");

	property p_posted;
		@(posedge clock_i) disable iff (rst_i)
		s_take_enc(32'h00000002) |=> (present_o == $past(cap_reg[1]));
	endproperty
	a_posted: assert property (p_posted)
		else $error("posted vector presence wrong");

endmodule // vm_field_encoding_decoder

/* verification/exec_unit_model.sv */
/*
 * Model of the execution logic that issues field encodings to the decoder.
 * Assumes one clock; the caller invokes issue or stop once per cycle.
 */
`timescale 1ns/1ns
module exec_unit_model (
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	// Request to decoder
	output logic             req_o = 1'b0,
	output logic [31:0]      enc_o = 32'h0
);
	logic        pend_v = 1'b0;
	logic [31:0] pend_e = 32'h0;

	// ************************************************************
	// Drive at rising edge; idle encoding keeps toggling
	// ************************************************************
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			req_o <= 1'b0;
			enc_o <= 32'h0;
		end else begin
			req_o <= pend_v;
			enc_o <= pend_v ? pend_e : ~enc_o;
		end
	end

	task automatic issue(input logic [31:0] e);
		#1;
		pend_v = 1'b1;
		pend_e = e;
		@(posedge clock_i);
	endtask

	task automatic stop();
		#1;
		pend_v = 1'b0;
		@(posedge clock_i);
	endtask
endmodule // exec_unit_model

/* verification/vm_field_encoding_decoder_test.sv */
/*
 * Self-checking bench for the field encoding decoder: table sweeps under
 * each control, reserved bits, register port, clock enable, random mix.
 * Assumes the register map and field numbering of the package.
 */
`timescale 1ns/1ns
module vm_field_encoding_decoder_test import field_dec_pkg::*; ;
	logic        clock_i = 1'b0;
	logic        rst_i   = 1'b1;
	logic        ce_i    = 1'b1;
	logic        wr_i    = 1'b0;
	logic        rd_i    = 1'b0;
	logic [7:0]  addr_i  = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	wire         req;
	wire  [31:0] enc;
	wire         done, high, present, invalid;
	wire  [5:0]  field_id;
	wire  [1:0]  wid, typ;
	wire  [8:0]  idx;
	wire  [31:0] rdata;
	int          n_errors = 0;
	int          cmp_count = 0;
	logic [15:0] cap_m = 16'h0, cnt_m = 16'h0, pend_cap = 16'h0;
	logic        pend = 1'b0, pend_ce = 1'b0;
	logic [31:0] pend_enc = 32'h0;
	logic [7:0]  xd;
	logic [22:0] got_v, exp_v;
	logic [15:0] c16m [0:4]  = '{M_VPROC_ID, M_POSTED, M_VE, M_LIN_XLAT, M_IPI};
	logic [15:0] g16m [0:10] = '{M_NONE, M_NONE, M_NONE, M_NONE, M_NONE, M_NONE, M_NONE,
		M_NONE, M_VINTR, M_PAGE_LOG, M_USER_VEC};
	logic [15:0] c64m [0:20] = '{M_NONE, M_NONE, M_MSRBMP, M_NONE, M_NONE, M_NONE, M_NONE,
		M_PAGE_LOG, M_NONE, M_TPR, M_APICACC, M_POSTED, M_VMFUNC, M_EPT, M_VINTR, M_VINTR,
		M_VINTR, M_VINTR, M_EPTPSW, M_SHADOW, M_SHADOW};

	always #4 clock_i = ~clock_i;

	exec_unit_model exec_u (.clock_i(clock_i), .rst_i(rst_i), .req_o(req), .enc_o(enc));

	vm_field_encoding_decoder dut_u (
		.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req), .enc_i(enc),
		.done_o(done), .field_id_o(field_id), .width_o(wid), .type_o(typ),
		.index_o(idx), .high_o(high), .present_o(present), .invalid_o(invalid),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata));

	// ************************************************************
	// Expected decode: {present, invalid, id}
	// ************************************************************
	function automatic logic [7:0] expect_f(input logic [31:0] e, input logic [15:0] c);
		logic [8:0]  i;
		logic [5:0]  id;
		logic [15:0] m;
		logic        p;
		i = e[9:1];
		id = 6'h00;
		m = 16'h0;
		if (e[31:15] == 17'h0 && !e[12]) begin
			if (e[14:13] == W16 && e[11:10] == T_CTRL && i <= 9'h004) begin
				id = 6'h01 + 6'(i);
				m = c16m[i];
			end else if (e[14:13] == W16 && e[11:10] == T_GUEST && i <= 9'h00A) begin
				id = 6'h06 + 6'(i);
				m = g16m[i];
			end else if (e[14:13] == W16 && e[11:10] == T_HOST && i <= 9'h006) begin
				id = 6'h11 + 6'(i);
			end else if (e[14:13] == W64 && e[11:10] == T_CTRL && i <= 9'h014) begin
				id = 6'h18 + 6'(i);
				m = c64m[i];
			end
		end
		p = id != 6'h00 && !(e[14:13] == W16 && e[0]) && (m == 16'h0 || (c & m) != 16'h0);
		return {p, !p, id};
	endfunction

	function automatic logic [31:0] status_f(input logic [31:0] e, input logic [15:0] c);
		logic [7:0] x;
		x = expect_f(e, c);
		return {10'h0, e[11:10], e[14:13], e[9:1], x[7], x[6], e[14:13] == W64 && e[0], x[5:0]};
	endfunction

	task automatic cmp_dec(input logic [22:0] got, input logic [22:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// ************************************************************
	// Decode result check, one cycle after each taken request
	// ************************************************************
	always @(posedge clock_i) begin
		pend <= ce_i && req;
		pend_ce <= ce_i;
		pend_enc <= enc;
		pend_cap <= cap_m;
	end

	always @(negedge clock_i) begin
		if (!rst_i && pend) begin
			xd = expect_f(pend_enc, pend_cap);
			got_v = {done, field_id, wid, typ, idx, high, present, invalid};
			exp_v = {1'b1, xd[5:0], pend_enc[14:13], pend_enc[11:10], pend_enc[9:1],
				pend_enc[14:13] == W64 && pend_enc[0], xd[7], xd[6]};
			cmp_dec(got_v, exp_v);
			if (xd[6])
				cnt_m++;
		end else if (!rst_i && pend_ce) begin
			cmp_dec({22'h0, done}, 23'h0);
		end
	end

	// ************************************************************
	// Register port and table sweep
	// ************************************************************
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clock_i);
		wr_i <= 1'b0;
		if (a == CAP_ADDR)
			cap_m = d[15:0];
		if (a == COUNT_ADDR)
			cnt_m = 16'h0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge clock_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 q = rdata;
	endtask

	task automatic run_tables();
		logic [31:0] base [0:3] = '{32'h0000, 32'h0800, 32'h0C00, 32'h2000};
		int          last [0:3] = '{4, 10, 6, 20};
		for (int g = 0; g < 4; g++) begin
			for (int i = 0; i <= last[g] + 1; i++) begin
				exec_u.issue(base[g] | 32'(i << 1));
				exec_u.issue(base[g] | 32'(i << 1) | 32'h1);
			end
		end
		exec_u.stop();
	endtask

	task automatic close_out();
		if (n_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#(8 * 30000);
		n_errors++;
		close_out();
	end

	initial begin
		logic [31:0] q;
		logic [31:0] e;
		q = $urandom(97714);
		repeat (10) @(posedge clock_i);
		rst_i <= 1'b0;
		reg_rd(CAP_ADDR, q);
		cmp_reg(q, 32'h0);
		reg_rd(COUNT_ADDR, q);
		cmp_reg(q, 32'h0);
		// Every table entry under no, each single and all controls
		for (int k = 0; k < 18; k++) begin
			reg_wr(CAP_ADDR, k == 16 ? 32'hFFFF : (k == 17 ? 32'h0 : 32'h1 << k));
			run_tables();
		end
		reg_rd(COUNT_ADDR, q);
		cmp_reg(q, {16'h0, cnt_m});
		reg_wr(COUNT_ADDR, 32'h0);
		// Reserved positions set
		foreach (c16m[j]) begin
			exec_u.issue(32'h0800 | (32'h1000 << (j * 4)));
		end
		exec_u.issue(32'h80002000);
		exec_u.stop();
		// Status, read-only status, unmapped place
		reg_wr(CAP_ADDR, 32'hFFFF);
		exec_u.issue(32'h2029);
		exec_u.stop();
		reg_rd(STAT_ADDR, q);
		cmp_reg(q, status_f(32'h2029, 16'hFFFF));
		@(posedge clock_i);
		#1 cmp_reg(rdata, 32'h0);
		reg_wr(STAT_ADDR, 32'hFFFFFFFF);
		reg_wr(8'h0C, 32'h1234);
		reg_rd(8'h0C, q);
		cmp_reg(q, 32'h0);
		reg_rd(CAP_ADDR, q);
		cmp_reg(q, 32'hFFFF);
		// Clock enable low: request ignored, result held
		@(posedge clock_i);
		ce_i <= 1'b0;
		exec_u.issue(32'h0800);
		exec_u.stop();
		@(posedge clock_i);
		ce_i <= 1'b1;
		reg_rd(STAT_ADDR, q);
		cmp_reg(q, status_f(32'h2029, 16'hFFFF));
		// Random mix, back to back, with control changes
		repeat (300) begin
			e = $urandom & 32'h00006FFF;
			if ($urandom % 4 != 0)
				e[9:6] = 4'h0;
			if ($urandom % 8 == 0)
				e = e | (32'h1 << (12 + $urandom % 20));
			if ($urandom % 32 == 0) begin
				exec_u.stop();
				reg_wr(CAP_ADDR, $urandom);
			end
			exec_u.issue(e);
		end
		exec_u.stop();
		repeat (2) @(posedge clock_i);
		reg_rd(COUNT_ADDR, q);
		cmp_reg(q, {16'h0, cnt_m});
		close_out();
	end
endmodule // vm_field_encoding_decoder_test
